// ==== pkg/kbc_pkg.sv ====
// constants and types shared by the keyboard controller host port
package kbc_pkg;
  // host port decode
  localparam logic [7:0] DATA_PORT_ADDR = 8'h60; // data port io address
  localparam logic [7:0] CMD_PORT_ADDR  = 8'h64; // command and status io address
  localparam int         ADDR_SEL_BIT   = 2;     // address bit that picks the port
  // status bit positions
  localparam int ST_OBF  = 0;
  localparam int ST_IBF  = 1;
  localparam int ST_SYS  = 2;
  localparam int ST_CD   = 3;
  localparam int ST_KEYBOARD_ENABLED_FLAG = 4;
  localparam int ST_B5   = 5;
  localparam int ST_B6   = 6;
  localparam int ST_PARITY_ERROR_FLAG = 7;
  // mode register bit positions and reset value
  localparam int         MODE_EKI   = 0;
  localparam int         MODE_SYS   = 2;
  localparam int         MODE_DKB   = 4;
  localparam logic [7:0] MODE_RESET = 8'h10;
  localparam logic [7:0] STAT_RESET = 8'h10;
  // command codes and error bytes
  localparam logic [7:0] CMD_READ_MODE  = 8'h20;
  localparam logic [7:0] CMD_WRITE_MODE = 8'h60;
  localparam logic [7:0] ERR_RX_BYTE    = 8'hFF;
  localparam logic [7:0] ERR_TX_BYTE    = 8'hFE;
  // serial frame
  localparam int FRAME_BITS     = 11;
  localparam int TIMEOUT_LCLKS  = 11;  // link clocks per frame; the timeout allows one more
  localparam int LCLK_NS        = 200; // nominal link clock period
  localparam int REF_CLK_NS     = 25;  // ref_clk period
  localparam int TIMEOUT_CYCLES = (TIMEOUT_LCLKS + 1) * LCLK_NS / REF_CLK_NS;
  // host strobes grouped
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       a2;
    logic [7:0] wdata;
  } host_bus_t;
  // mcu side request group
  typedef struct packed {
    logic       ob_load;   // load output buffer
    logic [7:0] ob_data;
    logic       ob_mouse;  // byte comes from mouse
    logic       ib_take;   // mcu reads input buffer
    logic       tx_start;  // start send to keyboard
    logic [7:0] tx_data;
  } mcu_req_t;
endpackage

// ==== rtl/kbc_serial.sv ====
// serial link engine: 11-bit frame receive and send on link clock falls
`timescale 1ns/1ps
`default_nettype none
module kbc_serial (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        lclk_fall,   // synchronised link clock falling edge
  input  wire logic        ldata_in,    // synchronised data line
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_data,
  output logic             ldata_oe,    // high while pulling data low
  output logic             rx_done,     // pulse, good or bad byte
  output logic [7:0]       rx_byte,
  output logic             rx_parity_error_flag,     // pulse with rx_done
  output logic             tx_done,
  output logic             rx_tmo,      // pulse, receive took too long
  output logic             tx_tmo,      // pulse, send took too long
  output logic             busy
);
  import kbc_pkg::*;
  typedef enum {S_IDLE, S_RX, S_TX} ser_state_t;
  ser_state_t  st_q, st_d;          // engine state
  logic [3:0]  cnt_q, cnt_d;        // bit counter
  logic [10:0] sh_q, sh_d;          // frame shift register
  logic [15:0] tmr_q, tmr_d;        // frame timer
  logic        oe_q, oe_d;          // data line drive
  logic        rxd_q, rxd_d, rxp_q, rxp_d, txd_q, txd_d, rto_q, rto_d, tto_q, tto_d;
  logic [7:0]  rxb_q, rxb_d;

  // next state of the frame engine
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    tmr_d = tmr_q;
    oe_d  = oe_q;
    rxb_d = rxb_q;
    rxd_d = 1'b0;
    rxp_d = 1'b0;
    txd_d = 1'b0;
    rto_d = 1'b0;
    tto_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        tmr_d = '0;
        if (tx_start) begin
          // start 0, data lsb first, odd parity, stop 1
          sh_d  = {1'b1, ~^tx_data, tx_data, 1'b0};
          cnt_d = '0;
          oe_d  = 1'b1;
          st_d  = S_TX;
        end else if (lclk_fall && !ldata_in) begin
          cnt_d = 4'd1;
          sh_d  = '0;
          st_d  = S_RX;
        end
      end
      S_RX: begin
        tmr_d = tmr_q + 16'd1;
        if (lclk_fall) begin
          sh_d  = {ldata_in, sh_q[10:1]};
          cnt_d = cnt_q + 4'd1;
          if (cnt_q == 4'(FRAME_BITS - 1)) begin
            rxd_d = 1'b1;
            rxb_d = sh_q[9:2]; // parity sits above the eight data bits
            rxp_d = ~^{sh_q[10:2]};
            st_d  = S_IDLE;
          end
        end
        if (tmr_q == 16'(TIMEOUT_CYCLES)) begin
          rto_d = 1'b1;
          st_d  = S_IDLE;
        end
      end
      S_TX: begin
        tmr_d = tmr_q + 16'd1;
        if (lclk_fall) begin
          cnt_d = cnt_q + 4'd1;
          sh_d  = {1'b1, sh_q[10:1]};
          oe_d  = ~sh_q[1];
          if (cnt_q == 4'(FRAME_BITS - 1)) begin
            oe_d  = 1'b0;
            txd_d = 1'b1;
            st_d  = S_IDLE;
          end
        end
        if (tmr_q == 16'(TIMEOUT_CYCLES)) begin
          tto_d = 1'b1;
          oe_d  = 1'b0;
          st_d  = S_IDLE;
        end
      end
    endcase
  end

  // register engine state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= S_IDLE;
      cnt_q <= '0;
      sh_q  <= '0;
      tmr_q <= '0;
      oe_q  <= 1'b0;
      rxb_q <= '0;
      rxd_q <= 1'b0;
      rxp_q <= 1'b0;
      txd_q <= 1'b0;
      rto_q <= 1'b0;
      tto_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      tmr_q <= tmr_d;
      oe_q  <= oe_d;
      rxb_q <= rxb_d;
      rxd_q <= rxd_d;
      rxp_q <= rxp_d;
      txd_q <= txd_d;
      rto_q <= rto_d;
      tto_q <= tto_d;
    end
  end

  assign ldata_oe = oe_q; // oe_q already tracks the inverse of the bit on the line
  assign rx_done  = rxd_q;
  assign rx_byte  = rxb_q;
  assign rx_parity_error_flag  = rxp_q;
  assign tx_done  = txd_q;
  assign rx_tmo   = rto_q;
  assign tx_tmo   = tto_q;
  assign busy     = (st_q != S_IDLE);
endmodule
`default_nettype wire

// ==== rtl/kbc_host_port.sv ====
// keyboard controller host port: data and status registers plus link
`timescale 1ns/1ps
`default_nettype none
module kbc_host_port (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire kbc_pkg::host_bus_t host_bus,   // host strobes, active low
  output logic [7:0]            host_rdata,   // read data
  output logic                  host_rdata_oe,// high while driving data bus
  input  wire kbc_pkg::mcu_req_t mcu_req,     // internal mcu requests
  output logic [7:0]            mcu_ib_data,  // input buffer to mcu
  output logic                  mcu_ib_is_cmd,// input byte was a command
  input  wire logic             ext_mode,     // extended status layout
  input  wire logic             kbd_inhibit,  // key switch inhibit
  input  wire logic             link_clock_line, // link clock pin
  input  wire logic             link_data_in, // link data pin level
  output logic                  link_data_oe, // pull data low
  output logic                  link_clock_oe,// hold link clock low
  output logic                  keyboard_interrupt,
  output logic [7:0]            mode_out      // mode register
);
  import kbc_pkg::*;

  // three-stage input synchronisers
  logic [2:0] lc_sync_q, ld_sync_q;
  logic       lc_stable_q, ld_stable_q;
  logic [2:0] cs_sync_q, rd_sync_q, wr_sync_q;
  logic       lclk_fall;
  logic       cs_stable_q, rd_stable_q, wr_stable_q; // filtered host strobes
  logic [2:0] inh_sync_q;                           // key switch synchroniser
  logic       inh_stable_q;                         // filtered key switch

  // registers of the port
  logic [7:0] output_buffer_q, output_buffer_d;
  logic [7:0] input_buffer_q, input_buffer_d;
  logic [7:0] mode_q, mode_d;
  logic       output_full_flag_q, output_full_flag_d;
  logic       input_full_flag_q, input_full_flag_d;
  logic       cmd_flag_q, cmd_flag_d;
  logic       parity_error_flag_q, parity_error_flag_d;
  logic       receive_timeout_flag_q, receive_timeout_flag_d;
  logic       transmit_timeout_flag_q, transmit_timeout_flag_d;
  logic       general_timeout_flag_q, general_timeout_flag_d;
  logic       outbuf_source_flag_q, outbuf_source_flag_d;
  logic       mode_wr_pend_q, mode_wr_pend_d;
  logic       irq_q, irq_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rdoe_q, rdoe_d;
  logic       rd_seen_q, rd_seen_d;
  logic       wr_seen_q, wr_seen_d;
  logic       kbd_en_q, kbd_en_d;
  logic [7:0] status;

  // serial engine results
  logic       rx_done, rx_parity_error_flag, tx_done, rx_tmo, tx_tmo, ser_busy, ser_oe;
  logic [7:0] rx_byte;

  // decode of a strobe: port 60h when address bit clear
  function automatic logic is_data_port(input logic a2);
    return (a2 == 1'b0);
  endfunction

  // level taken once stages two and three agree, else kept
  function automatic logic settle(input logic [2:0] s, input logic held);
    return (s[1] == s[2]) ? s[2] : held;
  endfunction

  // synchronise pins; edges read from stages two and three only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lc_sync_q   <= 3'h7;
      ld_sync_q   <= 3'h7;
      lc_stable_q <= 1'b1;
      ld_stable_q <= 1'b1;
      cs_sync_q   <= 3'h7;
      rd_sync_q   <= 3'h7;
      wr_sync_q   <= 3'h7;
      inh_sync_q  <= 3'h0;
      cs_stable_q <= 1'b1;
      rd_stable_q <= 1'b1;
      wr_stable_q <= 1'b1;
      inh_stable_q <= 1'b0;
    end else begin
      lc_sync_q <= {lc_sync_q[1:0], link_clock_line};
      ld_sync_q <= {ld_sync_q[1:0], link_data_in};
      cs_sync_q <= {cs_sync_q[1:0], host_bus.cs_n};
      rd_sync_q <= {rd_sync_q[1:0], host_bus.rd_n};
      wr_sync_q <= {wr_sync_q[1:0], host_bus.wr_n};
      inh_sync_q   <= {inh_sync_q[1:0], kbd_inhibit};
      cs_stable_q  <= settle(cs_sync_q, cs_stable_q);
      rd_stable_q  <= settle(rd_sync_q, rd_stable_q);
      wr_stable_q  <= settle(wr_sync_q, wr_stable_q);
      inh_stable_q <= settle(inh_sync_q, inh_stable_q);
      if (lc_sync_q[1] == lc_sync_q[2]) begin
        lc_stable_q <= lc_sync_q[2];
      end
      if (ld_sync_q[1] == ld_sync_q[2]) begin
        ld_stable_q <= ld_sync_q[2];
      end
    end
  end
  // falling edge of the filtered link clock
  assign lclk_fall = lc_stable_q & (lc_sync_q[1] == lc_sync_q[2]) & ~lc_sync_q[2];

  // frame engine
  kbc_serial u_serial (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .lclk_fall (lclk_fall),
    .ldata_in  (ld_stable_q),
    .tx_start  (mcu_req.tx_start),
    .tx_data   (mcu_req.tx_data),
    .ldata_oe  (ser_oe),
    .rx_done   (rx_done),
    .rx_byte   (rx_byte),
    .rx_parity_error_flag   (rx_parity_error_flag),
    .tx_done   (tx_done),
    .rx_tmo    (rx_tmo),
    .tx_tmo    (tx_tmo),
    .busy      (ser_busy)
  );

  // status byte, bits 6 and 5 follow the mode
  always_comb begin
    status          = '0;
    status[ST_PARITY_ERROR_FLAG] = parity_error_flag_q;
    status[ST_B6]   = ext_mode ? general_timeout_flag_q : receive_timeout_flag_q;
    status[ST_B5]   = ext_mode ? outbuf_source_flag_q : transmit_timeout_flag_q;
    status[ST_KEYBOARD_ENABLED_FLAG] = kbd_en_q;
    status[ST_CD]   = cmd_flag_q;
    status[ST_SYS]  = mode_q[MODE_SYS];
    status[ST_IBF]  = input_full_flag_q;
    status[ST_OBF]  = output_full_flag_q;
  end

  // host access, mcu loads and link events
  always_comb begin
    logic rd_now, wr_now, ob_load;
    logic [7:0] ob_val;
    rd_now  = 1'b0;
    wr_now  = 1'b0;
    ob_load = 1'b0;
    ob_val  = '0;
    output_buffer_d         = output_buffer_q;
    input_buffer_d          = input_buffer_q;
    mode_d                  = mode_q;
    output_full_flag_d      = output_full_flag_q;
    input_full_flag_d       = input_full_flag_q;
    cmd_flag_d              = cmd_flag_q;
    parity_error_flag_d     = parity_error_flag_q;
    receive_timeout_flag_d  = receive_timeout_flag_q;
    transmit_timeout_flag_d = transmit_timeout_flag_q;
    general_timeout_flag_d  = general_timeout_flag_q;
    outbuf_source_flag_d    = outbuf_source_flag_q;
    mode_wr_pend_d          = mode_wr_pend_q;
    kbd_en_d                = ~inh_stable_q;
    rdata_d                 = rdata_q;
    // strobes valid only with chip select low
    rd_seen_d = ~cs_stable_q & ~rd_stable_q;
    wr_seen_d = ~cs_stable_q & ~wr_stable_q;
    rdoe_d    = rd_seen_d;
    rd_now    = rd_seen_d & ~rd_seen_q;
    wr_now    = wr_seen_d & ~wr_seen_q;
    // mcu takes the input byte
    if (mcu_req.ib_take) begin
      input_full_flag_d = 1'b0;
    end
    // host read
    if (rd_now) begin
      if (is_data_port(host_bus.a2)) begin
        rdata_d            = output_buffer_q;
        output_full_flag_d = 1'b0;
      end else begin
        rdata_d = status;
      end
    end
    // host write
    if (wr_now) begin
      input_full_flag_d = 1'b1;
      if (is_data_port(host_bus.a2)) begin
        cmd_flag_d = 1'b0;
        if (mode_wr_pend_q) begin
          mode_d         = host_bus.wdata;
          mode_wr_pend_d = 1'b0;
          input_full_flag_d = 1'b0;
        end else begin
          input_buffer_d = host_bus.wdata;
        end
      end else begin
        cmd_flag_d     = 1'b1;
        input_buffer_d = host_bus.wdata;
        mode_wr_pend_d = 1'b0;
        if (host_bus.wdata == CMD_READ_MODE) begin
          ob_load           = 1'b1;
          ob_val            = mode_q;
          input_full_flag_d = 1'b0;
        end else if (host_bus.wdata == CMD_WRITE_MODE) begin
          mode_wr_pend_d    = 1'b1;
          input_full_flag_d = 1'b0;
        end
      end
    end
    // link events, later ones win the output buffer
    if (rx_done) begin
      ob_load              = 1'b1;
      ob_val               = rx_parity_error_flag ? ERR_RX_BYTE : rx_byte;
      parity_error_flag_d  = rx_parity_error_flag;
      outbuf_source_flag_d = 1'b0;
      receive_timeout_flag_d  = 1'b0;
      general_timeout_flag_d  = 1'b0;
    end
    if (tx_done) begin
      transmit_timeout_flag_d = 1'b0;
      general_timeout_flag_d  = 1'b0;
    end
    if (rx_tmo) begin
      receive_timeout_flag_d = 1'b1;
      general_timeout_flag_d = 1'b1;
      if (ext_mode) begin
        ob_load = 1'b1;
        ob_val  = ERR_RX_BYTE;
      end
    end
    if (tx_tmo) begin
      transmit_timeout_flag_d = 1'b1;
      general_timeout_flag_d  = 1'b1;
      if (ext_mode) begin
        ob_load = 1'b1;
        ob_val  = ERR_TX_BYTE;
      end
    end
    if (mcu_req.ob_load) begin
      ob_load              = 1'b1;
      ob_val               = mcu_req.ob_data;
      outbuf_source_flag_d = mcu_req.ob_mouse;
    end
    // any load sets the full flag; a same-cycle host read loses
    if (ob_load) begin
      output_buffer_d    = ob_val;
      output_full_flag_d = 1'b1;
    end
    irq_d = ob_load & mode_q[MODE_EKI];
  end

  // register port state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      output_buffer_q         <= '0;
      input_buffer_q          <= '0;
      mode_q                  <= MODE_RESET;
      output_full_flag_q      <= STAT_RESET[ST_OBF];
      input_full_flag_q       <= STAT_RESET[ST_IBF];
      cmd_flag_q              <= STAT_RESET[ST_CD];
      parity_error_flag_q     <= STAT_RESET[ST_PARITY_ERROR_FLAG];
      receive_timeout_flag_q  <= STAT_RESET[ST_B6];
      transmit_timeout_flag_q <= STAT_RESET[ST_B5];
      general_timeout_flag_q  <= STAT_RESET[ST_B6];
      outbuf_source_flag_q    <= STAT_RESET[ST_B5];
      kbd_en_q                <= STAT_RESET[ST_KEYBOARD_ENABLED_FLAG];
      mode_wr_pend_q          <= 1'b0;
      irq_q                   <= 1'b0;
      rdata_q                 <= '0;
      rdoe_q                  <= 1'b0;
      rd_seen_q               <= 1'b0;
      wr_seen_q               <= 1'b0;
    end else begin
      output_buffer_q         <= output_buffer_d;
      input_buffer_q          <= input_buffer_d;
      mode_q                  <= mode_d;
      output_full_flag_q      <= output_full_flag_d;
      input_full_flag_q       <= input_full_flag_d;
      cmd_flag_q              <= cmd_flag_d;
      parity_error_flag_q     <= parity_error_flag_d;
      receive_timeout_flag_q  <= receive_timeout_flag_d;
      transmit_timeout_flag_q <= transmit_timeout_flag_d;
      general_timeout_flag_q  <= general_timeout_flag_d;
      outbuf_source_flag_q    <= outbuf_source_flag_d;
      kbd_en_q                <= kbd_en_d;
      mode_wr_pend_q          <= mode_wr_pend_d;
      irq_q                   <= irq_d;
      rdata_q                 <= rdata_d;
      rdoe_q                  <= rdoe_d;
      rd_seen_q               <= rd_seen_d;
      wr_seen_q               <= wr_seen_d;
    end
  end

  // link clock hold flop for disable
  logic lclk_hold_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lclk_hold_q <= 1'b0;
    end else begin
      lclk_hold_q <= (mode_q[MODE_DKB] | ~kbd_en_q) & ~ser_busy;
    end
  end

  assign host_rdata         = rdata_q;
  assign host_rdata_oe      = rdoe_q;
  assign mcu_ib_data        = input_buffer_q;
  assign mcu_ib_is_cmd      = cmd_flag_q;
  assign link_data_oe       = ser_oe;
  assign link_clock_oe      = lclk_hold_q;
  assign keyboard_interrupt = irq_q;
  assign mode_out           = mode_q;
endmodule
`default_nettype wire

// ==== tb/kbc_host_port_checker.sv ====
// pin-level assertions for the keyboard controller host port
`timescale 1ns/1ps
`default_nettype none
module kbc_host_port_checker (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire kbc_pkg::host_bus_t host_bus,
  input wire logic [7:0]         host_rdata,
  input wire logic               host_rdata_oe,
  input wire kbc_pkg::mcu_req_t  mcu_req,
  input wire logic [7:0]         mcu_ib_data,
  input wire logic               mcu_ib_is_cmd,
  input wire logic               ext_mode,
  input wire logic               kbd_inhibit,
  input wire logic               link_clock_line,
  input wire logic               link_data_in,
  input wire logic               link_data_oe,
  input wire logic               link_clock_oe,
  input wire logic               keyboard_interrupt,
  input wire logic [7:0]         mode_out
);
  import kbc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // host strobes held long enough to be taken
  sequence rd_held;
    (!host_bus.cs_n && !host_bus.rd_n) [*6];
  endsequence
  sequence wr_cmd_held;
    (!host_bus.cs_n && !host_bus.wr_n && host_bus.a2) [*6];
  endsequence
  sequence wr_dat_held;
    (!host_bus.cs_n && !host_bus.wr_n && !host_bus.a2) [*6];
  endsequence
  read_drive_a: assert property (rd_held |-> host_rdata_oe)
    else $error("read strobe did not drive the data bus");
  cs_gate_a: assert property (host_bus.cs_n [*8] |-> !host_rdata_oe)
    else $error("data bus driven without chip select");
  cmd_flag_a: assert property (wr_cmd_held |-> mcu_ib_is_cmd)
    else $error("command write did not set command flag");
  data_flag_a: assert property (wr_dat_held |-> !mcu_ib_is_cmd)
    else $error("data write did not clear command flag");
  irq_on_load_a: assert property (mcu_req.ob_load && mode_out[MODE_EKI]
    |-> ##[1:3] keyboard_interrupt)
    else $error("no interrupt after output load");
  irq_pulse_a: assert property (keyboard_interrupt |=> !keyboard_interrupt)
    else $error("interrupt longer than one cycle");
  irq_gated_a: assert property (!mode_out[MODE_EKI] [*4] |-> !keyboard_interrupt)
    else $error("interrupt while disabled");
  mode_reset_a: assert property ($rose(reset_n) |-> mode_out == MODE_RESET)
    else $error("mode register wrong after reset");
  mode_host_a: assert property ($changed(mode_out) |-> !$past(host_bus.wr_n, 1))
    else $error("mode changed without host write");
  tx_start_a: assert property (mcu_req.tx_start && !link_data_oe
    |-> ##[1:4] link_data_oe)
    else $error("start bit not driven");
endmodule
bind kbc_host_port kbc_host_port_checker i_kbc_host_port_checker (.ref_clk, .reset_n,
  .host_bus, .host_rdata, .host_rdata_oe, .mcu_req, .mcu_ib_data, .mcu_ib_is_cmd, .ext_mode,
  .kbd_inhibit, .link_clock_line, .link_data_in, .link_data_oe, .link_clock_oe,
  .keyboard_interrupt, .mode_out);
`default_nettype wire

// ==== tb/kbd_link_model.sv ====
// behavioural keyboard on the open-drain link
`timescale 1ns/1ps
`default_nettype none
module kbd_link_model (
  input  wire logic link_clock_oe,
  input  wire logic link_data_oe,
  output logic      link_clock_line,
  output logic      link_data_in
);
  logic clk_low; // keyboard pulls clock low
  logic dat_low; // keyboard pulls data low
  // both lines have pull-ups, either party may pull low
  assign link_clock_line = !(clk_low || link_clock_oe);
  assign link_data_in    = !(dat_low || link_data_oe);
  initial begin
    clk_low = 1'b0;
    dat_low = 1'b0;
  end
  // frame to controller, fewer than eleven bits leaves it unfinished
  task automatic send(input logic [7:0] b, input logic bad, input int nbits);
    logic [10:0] f;
    f = {1'b1, ^b ^ !bad, b, 1'b0};
    for (int i = 0; i < nbits; i++) begin
      dat_low = !f[i];
      #100;
      clk_low = 1'b1;
      #100;
      clk_low = 1'b0;
    end
    dat_low = 1'b0;
  endtask
  // clock eleven bits out of the controller, sampled at each fall
  task automatic recv(output logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      #100;
      f[i] = link_data_in;
      clk_low = 1'b1;
      #100;
      clk_low = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking testbench for the keyboard controller host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kbc_pkg::*;
  localparam logic PD = DATA_PORT_ADDR[ADDR_SEL_BIT]; // a2 for data port
  localparam logic PC = CMD_PORT_ADDR[ADDR_SEL_BIT];  // a2 for command port
  logic       ref_clk, reset_n, ext_mode, kbd_inhibit, host_rdata_oe, mcu_ib_is_cmd;
  logic       link_clock_line, link_data_in, link_data_oe, link_clock_oe, keyboard_interrupt;
  logic [7:0] host_rdata, mcu_ib_data, mode_out, rd_v;
  logic [10:0] fr;
  host_bus_t  host_bus;
  mcu_req_t   mcu_req;
  int         error_cnt, n_tests, cyc, irq_cnt, i0;
  kbc_host_port i_kbc_host_port (.ref_clk, .reset_n, .host_bus, .host_rdata, .host_rdata_oe,
    .mcu_req, .mcu_ib_data, .mcu_ib_is_cmd, .ext_mode, .kbd_inhibit, .link_clock_line,
    .link_data_in, .link_data_oe, .link_clock_oe, .keyboard_interrupt, .mode_out);
  kbd_link_model i_kbd_link_model (.link_clock_oe, .link_data_oe, .link_clock_line,
    .link_data_in);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // one host cycle: strobe held six clocks, then four idle
  task automatic acc(input logic wr, input logic a, input logic [7:0] d, input logic cs = 1'b0);
    host_bus = '{cs_n: cs, rd_n: wr, wr_n: !wr, a2: a, wdata: d};
    step(6);
    rd_v = host_rdata;
    host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a2: a, wdata: d};
    step(4);
  endtask
  task automatic rd_chk(input logic a, input logic [7:0] m, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check(rd_v & m, exp);
  endtask
  // one-cycle request from the internal controller
  task automatic mcu(input mcu_req_t r);
    mcu_req = r;
    step(1);
    mcu_req = '0;
    step(4);
  endtask
  always #12.5 ref_clk = ~ref_clk;
  // interrupt counting and hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (keyboard_interrupt === 1'b1) irq_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    {cyc, irq_cnt, error_cnt, n_tests, i0} = '0;
    host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a2: 1'b0, wdata: 8'h00};
    mcu_req = '0;
    ext_mode = 1'b0;
    kbd_inhibit = 1'b0;
    step(5);
    reset_n = 1'b1;
    step(2);
    rd_chk(PC, 8'hFF, STAT_RESET);
    check(mode_out, MODE_RESET);
    $display("test reset done");
    acc(1'b1, PC, CMD_WRITE_MODE);
    acc(1'b1, PD, 8'h05);
    check(mode_out, 8'h05);
    rd_chk(PC, 8'hFF, 8'h14);
    rd_chk(PC, 8'hFF, 8'h14);
    i0 = irq_cnt;
    acc(1'b1, PC, CMD_READ_MODE);
    rd_chk(PC, 8'hFF, 8'h1D);
    rd_chk(PD, 8'hFF, 8'h05);
    rd_chk(PC, 8'hFF, 8'h1C);
    check(8'(irq_cnt - i0), 8'h01);
    $display("test mode done");
    acc(1'b1, PD, 8'hA5);
    rd_chk(PC, 8'hFF, 8'h16);
    check(mcu_ib_data, 8'hA5);
    mcu('{ib_take: 1'b1, default: '0});
    rd_chk(PC, 8'hFF, 8'h14);
    acc(1'b1, PC, 8'hAA);
    rd_chk(PC, 8'hFF, 8'h1E);
    mcu('{ib_take: 1'b1, default: '0});
    acc(1'b1, PD, 8'h77, 1'b1);
    rd_chk(PC, 8'hFF, 8'h1C);
    $display("test buffers done");
    ext_mode = 1'b1;
    mcu('{ob_load: 1'b1, ob_data: 8'h3C, ob_mouse: 1'b1, default: '0});
    rd_chk(PC, 8'h21, 8'h21);
    rd_chk(PD, 8'hFF, 8'h3C);
    mcu('{ob_load: 1'b1, ob_data: 8'h3D, default: '0});
    rd_chk(PC, 8'h21, 8'h01);
    rd_chk(PD, 8'hFF, 8'h3D);
    ext_mode = 1'b0;
    kbd_inhibit = 1'b1;
    step(4);
    rd_chk(PC, 8'h10, 8'h00);
    check({7'h0, link_clock_oe}, 8'h01);
    kbd_inhibit = 1'b0;
    step(8);
    check({7'h0, link_clock_oe}, 8'h00);
    $display("test source done");
    i_kbd_link_model.send(8'h5A, 1'b0, 11);
    step(10);
    rd_chk(PC, 8'h81, 8'h01);
    rd_chk(PD, 8'hFF, 8'h5A);
    i_kbd_link_model.send(8'h33, 1'b1, 11);
    step(10);
    rd_chk(PC, 8'h81, 8'h81);
    rd_chk(PD, 8'hFF, ERR_RX_BYTE);
    fork
      mcu('{tx_start: 1'b1, tx_data: 8'hC6, default: '0});
      i_kbd_link_model.recv(fr);
    join
    step(20);
    check(fr[8:1], 8'hC6);
    check({5'h0, fr[10], fr[9], fr[0]}, {5'h0, 1'b1, ~^8'hC6, 1'b0});
    $display("test link done");
    i_kbd_link_model.send(8'h11, 1'b0, 4);
    step(150);
    rd_chk(PC, 8'h40, 8'h40);
    mcu('{tx_start: 1'b1, tx_data: 8'hC6, default: '0});
    step(150);
    rd_chk(PC, 8'h20, 8'h20);
    acc(1'b0, PD, 8'h00);
    ext_mode = 1'b1;
    i_kbd_link_model.send(8'h11, 1'b0, 4);
    step(150);
    rd_chk(PC, 8'h41, 8'h41);
    rd_chk(PD, 8'hFF, ERR_RX_BYTE);
    mcu('{tx_start: 1'b1, tx_data: 8'hC6, default: '0});
    step(150);
    rd_chk(PC, 8'h41, 8'h41);
    rd_chk(PD, 8'hFF, ERR_TX_BYTE);
    $display("test timeout done");
    complete_run();
  end
endmodule
`default_nettype wire
